// ===== core/acr_regbank.sv
// configuration register bank of the sampling converter, serial port slave
//
// Overview of operation
// - Every register but the rate override takes effect the moment it is written.
// - Rate override stays staged until transfer bit 0 is written high.
// - Channel index bits 3:0 pick data channels for local writes.
// - Channel index bits 5:4 pick output-clock channels for local writes.
// - Global settings apply to all channels whatever the selection.
// - Two 16-bit user patterns, each split over a low and high byte.
// - I/O control two bit 0 disables the data pin pull-down.
// - I/O control three bit 3 powers down the common-mode generator.
`timescale 1ns/1ns
module acr_regbank (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial port pins
    input wire logic sclk,
    input wire logic csb_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    // sync event pin
    input wire logic sync_in,
    // settings to the converter core
    output logic [2:0] ref_span,
    output logic [15:0] pattern_one,
    output logic [15:0] pattern_two,
    output logic [7:0] serial_out_ctrl,
    output logic [acr_pkg::NUM_CH-1:0] chan_powerdown,
    output logic [acr_pkg::NUM_CH-1:0] chan_out_reset,
    output logic rate_override_en,
    output logic [2:0] rate_code,
    output logic pulldown_off,
    output logic cm_gen_powerdown,
    output logic sync_pulse
);

    logic [3:0] pins_s;
    acr_pkg::acr_wr_t wr;
    acr_pkg::acr_rd_t rd;
    logic [7:0] rd_data;
    logic [7:0] chan_index_q;
    logic [7:0] ref_span_q;
    logic [7:0] patt1_lo_q;
    logic [7:0] patt1_hi_q;
    logic [7:0] patt2_lo_q;
    logic [7:0] patt2_hi_q;
    logic [7:0] ser_ctrl_q;
    logic [7:0] ch_stat_q [acr_pkg::NUM_CH];
    logic [7:0] rate_staged_q;
    logic [7:0] rate_applied_q;
    logic [7:0] io2_q;
    logic [7:0] io3_q;
    logic [7:0] sync_ctrl_q;
    logic sync_d_q;
    logic sync_used_q;
    logic sync_edge;
    logic sync_go;
    logic commit;

    // pins cross into mclk through two flops each
    acr_sync #(.WIDTH(4)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({sync_in, sdio_in, csb_n, sclk}),
        .sync_out(pins_s)
    );

    acr_serial u_serial (
        .mclk(mclk),
        .rst(rst),
        .sclk_s(pins_s[0]),
        .csb_s(pins_s[1]),
        .sdin_s(pins_s[2]),
        .wr(wr),
        .rd(rd),
        .rd_data(rd_data),
        .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n)
    );

    // channel index selects data and clock channels for local writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_index_q <= acr_pkg::RST_CHAN_INDEX;
        end else if (wr.valid && wr.addr == acr_pkg::ADDR_CHAN_INDEX) begin
            chan_index_q <= wr.data & acr_pkg::MASK_CHAN_INDEX;
        end
    end

    // global settings, applied straight on write whatever the selection
    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_span_q <= acr_pkg::RST_REF_SPAN;
            ser_ctrl_q <= acr_pkg::RST_SER_OUT_CTRL;
            io2_q <= acr_pkg::RST_IO_CTRL;
            io3_q <= acr_pkg::RST_IO_CTRL;
        end else if (wr.valid) begin
            if (wr.addr == acr_pkg::ADDR_REF_SPAN) begin
                ref_span_q <= wr.data & acr_pkg::MASK_REF_SPAN;
            end else if (wr.addr == acr_pkg::ADDR_SER_OUT_CTRL) begin
                ser_ctrl_q <= wr.data & acr_pkg::MASK_SER_OUT_CTRL;
            end else if (wr.addr == acr_pkg::ADDR_IO_CTRL2) begin
                io2_q <= wr.data & acr_pkg::MASK_IO_CTRL2;
            end else if (wr.addr == acr_pkg::ADDR_IO_CTRL3) begin
                io3_q <= wr.data & acr_pkg::MASK_IO_CTRL3;
            end
        end
    end

    // user pattern bytes, low byte and high byte of each word
    always_ff @(posedge mclk) begin
        if (rst) begin
            patt1_lo_q <= acr_pkg::RST_PATT;
            patt1_hi_q <= acr_pkg::RST_PATT;
            patt2_lo_q <= acr_pkg::RST_PATT;
            patt2_hi_q <= acr_pkg::RST_PATT;
        end else if (wr.valid) begin
            if (wr.addr == acr_pkg::ADDR_PATT1_LOW) begin
                patt1_lo_q <= wr.data;
            end else if (wr.addr == acr_pkg::ADDR_PATT1_HIGH) begin
                patt1_hi_q <= wr.data;
            end else if (wr.addr == acr_pkg::ADDR_PATT2_LOW) begin
                patt2_lo_q <= wr.data;
            end else if (wr.addr == acr_pkg::ADDR_PATT2_HIGH) begin
                patt2_hi_q <= wr.data;
            end
        end
    end

    // local channel status, one copy per data and clock channel
    for (genvar g = 0; g < acr_pkg::NUM_CH; g++) begin : g_chan
        always_ff @(posedge mclk) begin
            if (rst) begin
                ch_stat_q[g] <= acr_pkg::RST_CHAN_STATUS;
            end else if (wr.valid && wr.addr == acr_pkg::ADDR_CHAN_STATUS &&
                chan_index_q[g]) begin
                ch_stat_q[g] <= wr.data & acr_pkg::MASK_CHAN_STATUS;
            end
        end
        assign chan_powerdown[g] = ch_stat_q[g][acr_pkg::BIT_CH_POWERDOWN];
        assign chan_out_reset[g] = ch_stat_q[g][acr_pkg::BIT_CH_OUT_RESET];
    end

    // rate override is staged, then applied by the transfer bit
    assign commit = wr.valid && wr.addr == acr_pkg::ADDR_TRANSFER &&
        wr.data[acr_pkg::BIT_COMMIT];
    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_staged_q <= acr_pkg::RST_RATE_OVR;
            rate_applied_q <= acr_pkg::RST_RATE_OVR;
        end else begin
            if (wr.valid && wr.addr == acr_pkg::ADDR_RATE_OVR) begin
                rate_staged_q <= wr.data & acr_pkg::MASK_RATE_OVR;
            end
            if (commit) begin
                rate_applied_q <= rate_staged_q;
            end
        end
    end

    // sync control register
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_ctrl_q <= acr_pkg::RST_SYNC;
        end else if (wr.valid && wr.addr == acr_pkg::ADDR_SYNC) begin
            sync_ctrl_q <= wr.data & acr_pkg::MASK_SYNC;
        end
    end

    // sync events; in next-only mode later events are ignored until rewrite
    assign sync_edge = pins_s[3] & ~sync_d_q;
    assign sync_go = sync_edge && sync_ctrl_q[acr_pkg::BIT_SYNC_EN] &&
        !(sync_ctrl_q[acr_pkg::BIT_SYNC_NEXT] && sync_used_q);
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_d_q <= 1'b0;
            sync_used_q <= 1'b0;
            sync_pulse <= 1'b0;
        end else begin
            sync_d_q <= pins_s[3];
            sync_pulse <= sync_go;
            if (sync_go && sync_ctrl_q[acr_pkg::BIT_SYNC_NEXT]) begin
                sync_used_q <= 1'b1; // event wins over a rewrite
            end else if (wr.valid && wr.addr == acr_pkg::ADDR_SYNC) begin
                sync_used_q <= 1'b0;
            end
        end
    end

    // read-back; local status shows the lowest selected channel
    always_comb begin
        rd_data = 8'h00;
        if (rd.addr == acr_pkg::ADDR_CHAN_INDEX) begin
            rd_data = chan_index_q;
        end else if (rd.addr == acr_pkg::ADDR_REF_SPAN) begin
            rd_data = ref_span_q;
        end else if (rd.addr == acr_pkg::ADDR_PATT1_LOW) begin
            rd_data = patt1_lo_q;
        end else if (rd.addr == acr_pkg::ADDR_PATT1_HIGH) begin
            rd_data = patt1_hi_q;
        end else if (rd.addr == acr_pkg::ADDR_PATT2_LOW) begin
            rd_data = patt2_lo_q;
        end else if (rd.addr == acr_pkg::ADDR_PATT2_HIGH) begin
            rd_data = patt2_hi_q;
        end else if (rd.addr == acr_pkg::ADDR_SER_OUT_CTRL) begin
            rd_data = ser_ctrl_q;
        end else if (rd.addr == acr_pkg::ADDR_CHAN_STATUS) begin
            for (int i = acr_pkg::NUM_CH - 1; i >= 0; i--) begin
                if (chan_index_q[i]) begin
                    rd_data = ch_stat_q[i];
                end
            end
        end else if (rd.addr == acr_pkg::ADDR_RATE_OVR) begin
            rd_data = rate_staged_q;
        end else if (rd.addr == acr_pkg::ADDR_IO_CTRL2) begin
            rd_data = io2_q;
        end else if (rd.addr == acr_pkg::ADDR_IO_CTRL3) begin
            rd_data = io3_q;
        end else if (rd.addr == acr_pkg::ADDR_SYNC) begin
            rd_data = sync_ctrl_q;
        end
    end

    // settings out, every one straight from its register
    assign ref_span = ref_span_q[2:0];
    assign pattern_one = {patt1_hi_q, patt1_lo_q};
    assign pattern_two = {patt2_hi_q, patt2_lo_q};
    assign serial_out_ctrl = ser_ctrl_q;
    assign rate_override_en = rate_applied_q[6];
    assign rate_code = rate_applied_q[2:0];
    assign pulldown_off = io2_q[acr_pkg::BIT_PULLDOWN_OFF];
    assign cm_gen_powerdown = io3_q[acr_pkg::BIT_CM_POWERDOWN];

    // checks
    a_pattern_immediate: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_PATT1_LOW
        |=> pattern_one[7:0] == $past(wr.data))
        else $error("pattern one low byte not applied on write");

    a_rate_staged_hold: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_RATE_OVR
        |=> $stable({rate_override_en, rate_code}))
        else $error("rate override applied without transfer");

    a_rate_commit: assert property (@(posedge mclk)
        disable iff (rst)
        commit |=> rate_code == $past(rate_staged_q[2:0]) &&
        rate_override_en == $past(rate_staged_q[6]))
        else $error("transfer did not apply staged rate override");

    a_local_unselected: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_CHAN_STATUS && !chan_index_q[0]
        |=> $stable(chan_powerdown[0]))
        else $error("unselected data channel changed");

    a_clock_chan_sel: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_CHAN_STATUS && chan_index_q[4]
        |=> chan_powerdown[4] == $past(wr.data[0]))
        else $error("selected clock channel not written");

    a_clock_unselected: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_CHAN_STATUS && !chan_index_q[5]
        |=> $stable(chan_out_reset[5]))
        else $error("unselected clock channel changed");

    a_global_ignores_sel: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_SER_OUT_CTRL
        |=> serial_out_ctrl ==
        ($past(wr.data) & acr_pkg::MASK_SER_OUT_CTRL))
        else $error("global setting not applied to all channels");

    a_pattern_two_high: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_PATT2_HIGH
        |=> pattern_two[15:8] == $past(wr.data) && $stable(pattern_two[7:0]))
        else $error("pattern two high byte misplaced");

    a_pulldown_bit: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_IO_CTRL2
        |=> pulldown_off == $past(wr.data[0]))
        else $error("pull-down control not bit 0");

    a_cm_powerdown: assert property (@(posedge mclk)
        disable iff (rst)
        wr.valid && wr.addr == acr_pkg::ADDR_IO_CTRL3
        |=> cm_gen_powerdown == $past(wr.data[3]))
        else $error("common-mode power-down not bit 3");

    a_sync_once_only: assert property (@(posedge mclk)
        disable iff (rst)
        sync_used_q && sync_ctrl_q[acr_pkg::BIT_SYNC_NEXT] && !(wr.valid &&
        wr.addr == acr_pkg::ADDR_SYNC) |=> !sync_pulse)
        else $error("sync acted twice in next-only mode");

    a_sync_disabled: assert property (@(posedge mclk)
        disable iff (rst)
        !sync_ctrl_q[acr_pkg::BIT_SYNC_EN] |=> !sync_pulse)
        else $error("sync acted while disabled");

    a_sync_single_pulse: assert property (@(posedge mclk)
        disable iff (rst)
        sync_pulse |=> !sync_pulse)
        else $error("sync pulse longer than one cycle");

    // the data pin is let go whenever the chip is deselected
    a_pin_released: assert property (@(posedge mclk)
        disable iff (rst)
        pins_s[1] |=> sdio_oe_n)
        else $error("data pin driven while deselected");

endmodule : acr_regbank

// ===== core/acr_pkg.sv
// constants and carrier types for the converter configuration register bank
package acr_pkg;

    // channel counts: four data channels, then two output-clock channels
    localparam int NUM_DATA_CH = 4;
    localparam int NUM_CLK_CH = 2;
    localparam int NUM_CH = 6;

    // serial frame layout
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam int INSTR_RW_BIT = 15;

    // register addresses
    localparam logic [12:0] ADDR_CHAN_INDEX = 13'h0005;
    localparam logic [12:0] ADDR_REF_SPAN = 13'h0018;
    localparam logic [12:0] ADDR_PATT1_LOW = 13'h0019;
    localparam logic [12:0] ADDR_PATT1_HIGH = 13'h001a;
    localparam logic [12:0] ADDR_PATT2_LOW = 13'h001b;
    localparam logic [12:0] ADDR_PATT2_HIGH = 13'h001c;
    localparam logic [12:0] ADDR_SER_OUT_CTRL = 13'h0021;
    localparam logic [12:0] ADDR_CHAN_STATUS = 13'h0022;
    localparam logic [12:0] ADDR_TRANSFER = 13'h00ff;
    localparam logic [12:0] ADDR_RATE_OVR = 13'h0100;
    localparam logic [12:0] ADDR_IO_CTRL2 = 13'h0101;
    localparam logic [12:0] ADDR_IO_CTRL3 = 13'h0102;
    localparam logic [12:0] ADDR_SYNC = 13'h0109;

    // values after reset
    localparam logic [7:0] RST_CHAN_INDEX = 8'h3f;
    localparam logic [7:0] RST_REF_SPAN = 8'h04;
    localparam logic [7:0] RST_PATT = 8'h00;
    localparam logic [7:0] RST_SER_OUT_CTRL = 8'h30;
    localparam logic [7:0] RST_CHAN_STATUS = 8'h00;
    localparam logic [7:0] RST_RATE_OVR = 8'h00;
    localparam logic [7:0] RST_IO_CTRL = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h00;

    // writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_CHAN_INDEX = 8'h3f;
    localparam logic [7:0] MASK_REF_SPAN = 8'h07;
    localparam logic [7:0] MASK_SER_OUT_CTRL = 8'hf7;
    localparam logic [7:0] MASK_CHAN_STATUS = 8'h03;
    localparam logic [7:0] MASK_RATE_OVR = 8'h47;
    localparam logic [7:0] MASK_IO_CTRL2 = 8'h01;
    localparam logic [7:0] MASK_IO_CTRL3 = 8'h08;
    localparam logic [7:0] MASK_SYNC = 8'h03;

    // field positions
    localparam int BIT_COMMIT = 0;
    localparam int BIT_CH_POWERDOWN = 0;
    localparam int BIT_CH_OUT_RESET = 1;
    localparam int BIT_PULLDOWN_OFF = 0;
    localparam int BIT_CM_POWERDOWN = 3;
    localparam int BIT_SYNC_EN = 0;
    localparam int BIT_SYNC_NEXT = 1;

    // register write carried from the serial front end
    typedef struct packed {
        logic valid;
        logic [12:0] addr;
        logic [7:0] data;
    } acr_wr_t;

    // register read request carried from the serial front end
    typedef struct packed {
        logic req;
        logic [12:0] addr;
    } acr_rd_t;

endpackage : acr_pkg

// ===== core/acr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module acr_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // asynchronous levels and their synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : acr_sync

// ===== core/acr_serial.sv
// serial port front end: frames instruction and data bits into accesses
`timescale 1ns/1ns
module acr_serial (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // synchronised serial pins
    input wire logic sclk_s,
    input wire logic csb_s,
    input wire logic sdin_s,
    // register side
    output acr_pkg::acr_wr_t wr,
    output acr_pkg::acr_rd_t rd,
    input wire logic [7:0] rd_data,
    // serial data out, enable low while driving
    output logic sdio_out,
    output logic sdio_oe_n
);

    logic sclk_d_q;
    logic rise;
    logic fall;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;
    logic [15:0] instr;
    logic data_ph_q;
    logic is_read_q;
    logic [12:0] addr_q;
    logic [7:0] out_sr_q;

    // sclk edges seen in the mclk domain
    assign rise = sclk_s & ~sclk_d_q;
    assign fall = ~sclk_s & sclk_d_q;
    assign instr = {shift_q[14:0], sdin_s};

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    // bit counting, instruction capture and address stepping
    always_ff @(posedge mclk) begin
        if (rst || csb_s) begin
            cnt_q <= 5'h00;
            shift_q <= 16'h0000;
            data_ph_q <= 1'b0;
            is_read_q <= 1'b0;
            addr_q <= 13'h0000;
        end else if (rise) begin
            shift_q <= instr;
            if (!data_ph_q && cnt_q == acr_pkg::INSTR_LAST) begin
                is_read_q <= instr[acr_pkg::INSTR_RW_BIT];
                addr_q <= instr[12:0];
                data_ph_q <= 1'b1;
                cnt_q <= 5'h00;
            end else if (data_ph_q && cnt_q == acr_pkg::BYTE_LAST) begin
                addr_q <= addr_q + 13'h0001; // streaming to the next address
                cnt_q <= 5'h00;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // one-cycle write and read request pulses
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr <= '0;
            rd <= '0;
        end else begin
            wr.valid <= rise && !csb_s && data_ph_q && !is_read_q &&
                cnt_q == acr_pkg::BYTE_LAST;
            wr.addr <= addr_q;
            wr.data <= instr[7:0];
            if (rise && !csb_s && !data_ph_q &&
                cnt_q == acr_pkg::INSTR_LAST) begin
                rd.req <= instr[acr_pkg::INSTR_RW_BIT];
                rd.addr <= instr[12:0];
            end else if (rise && !csb_s && data_ph_q && is_read_q &&
                cnt_q == acr_pkg::BYTE_LAST) begin
                rd.req <= 1'b1;
                rd.addr <= addr_q + 13'h0001;
            end else begin
                rd.req <= 1'b0;
            end
        end
    end

    // read data leaves msb first on falling sclk edges
    always_ff @(posedge mclk) begin
        if (rst || csb_s) begin
            out_sr_q <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe_n <= 1'b1;
        end else if (rd.req) begin
            out_sr_q <= rd_data;
        end else if (fall && data_ph_q && is_read_q) begin
            sdio_out <= out_sr_q[7];
            sdio_oe_n <= 1'b0;
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
    end

endmodule : acr_serial

// ===== tb/acr_host_model.sv
// serial port host model: frames register writes and reads on the pins
`timescale 1ns/1ns
module acr_host_model #(
    parameter int HALF = 8
) (
    // clock
    input wire logic mclk,
    // serial pins toward the bank
    output logic sclk,
    output logic csb_n,
    output logic sdio_in,
    // bank side of the shared data pin
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic pulldown_off
);
    logic drv_q;
    logic bit_q;

    // idle pins at time zero: clock low, chip deselected, line released
    initial begin
        sclk = 1'b0;
        csb_n = 1'b1;
        drv_q = 1'b0;
        bit_q = 1'b0;
    end

    // resolved level of the shared data pin as every party sees it
    always_comb begin
        if (!sdio_oe_n) begin
            sdio_in = sdio_out;
        end else if (drv_q) begin
            sdio_in = bit_q;
        end else begin
            // pull-down holds it low; without it the line reads the inverse of the last host bit
            sdio_in = pulldown_off ? ~bit_q : 1'b0;
        end
    end

    // one frame: 16 instruction bits then one data byte, msb first
    task automatic frame(input logic rd, input logic [12:0] addr,
                         input logic [7:0] wdat, output logic [7:0] rdat);
        logic [23:0] word;
        word = {rd, 2'b00, addr, wdat};
        rdat = 8'h00;
        @(posedge mclk);
        csb_n <= 1'b0;
        drv_q <= 1'b1;
        for (int i = 23; i >= 0; i--) begin
            @(posedge mclk);
            // data phase of a read: let go of the line for the bank
            if (rd && i < 8) begin
                drv_q <= 1'b0;
            end else begin
                bit_q <= word[i];
            end
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b1;
            if (i < 8) begin
                rdat[i] = sdio_in;
            end
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge mclk);
        csb_n <= 1'b1;
        drv_q <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : frame
endmodule : acr_host_model

// ===== tb/tb_top.sv
// self-checking bench for the converter configuration register bank
`timescale 1ns/1ns
module tb_top;
    localparam int LIMIT = 60000;
    logic mclk, rst, sclk, csb_n, sdio_in, sdio_out, sdio_oe_n, sync_in;
    logic [2:0] ref_span, rate_code;
    logic [15:0] pattern_one, pattern_two;
    logic [7:0] serial_out_ctrl;
    logic [acr_pkg::NUM_CH-1:0] chan_powerdown, chan_out_reset;
    logic rate_override_en, pulldown_off, cm_gen_powerdown, sync_pulse;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int syncs = 0;

    // bank under test
    acr_regbank dut (
        .mclk(mclk), .rst(rst), .sclk(sclk), .csb_n(csb_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .sync_in(sync_in), .ref_span(ref_span), .pattern_one(pattern_one),
        .pattern_two(pattern_two), .serial_out_ctrl(serial_out_ctrl),
        .chan_powerdown(chan_powerdown), .chan_out_reset(chan_out_reset),
        .rate_override_en(rate_override_en), .rate_code(rate_code),
        .pulldown_off(pulldown_off), .cm_gen_powerdown(cm_gen_powerdown),
        .sync_pulse(sync_pulse)
    );

    // serial host on the far side
    acr_host_model host (
        .mclk(mclk), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .pulldown_off(pulldown_off)
    );

    // clock source
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // pulse counter and hang guard
    always @(posedge mclk) begin
        cycles++;
        if (sync_pulse === 1'b1) syncs++;
        if (cycles == LIMIT) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.frame(1'b0, a, d, unused);
        repeat (4) @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.frame(1'b1, a, 8'h00, v);
        chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, v});
    endtask : rd

    // one rising edge on the sync pin, then time for the pulse
    task automatic sync_event;
        @(posedge mclk);
        sync_in <= 1'b1;
        repeat (3) @(posedge mclk);
        sync_in <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask : sync_event

    // values after reset, plus an unmapped address
    task automatic t_reset;
        logic [12:0] a [14];
        logic [7:0] e [14];
        a = '{13'h005, 13'h018, 13'h019, 13'h01a, 13'h01b, 13'h01c, 13'h021,
              13'h022, 13'h0ff, 13'h100, 13'h101, 13'h102, 13'h109, 13'h030};
        e = '{8'h3f, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30,
              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        chk("ref_span", 16'h0004, {13'h0, ref_span});
        chk("serial_out_ctrl", 16'h0030, {8'h00, serial_out_ctrl});
        chk("sdio_oe_n", 16'h0001, {15'h0, sdio_oe_n});
        for (int i = 0; i < 14; i++) rd(a[i], e[i]);
    endtask : t_reset

    // settings take effect on the write itself
    task automatic t_immediate;
        wr(13'h019, 8'ha5);
        chk("pattern_one", 16'h00a5, pattern_one);
        wr(13'h01a, 8'h3c);
        chk("pattern_one", 16'h3ca5, pattern_one);
        wr(13'h01b, 8'h0f);
        wr(13'h01c, 8'hf0);
        chk("pattern_two", 16'hf00f, pattern_two);
        rd(13'h01c, 8'hf0);
        wr(13'h018, 8'hff);
        chk("ref_span", 16'h0007, {13'h0, ref_span});
        wr(13'h021, 8'hff);
        chk("serial_out_ctrl", 16'h00f7, {8'h00, serial_out_ctrl});
        wr(13'h101, 8'h01);
        chk("pulldown_off", 16'h0001, {15'h0, pulldown_off});
        rd(13'h101, 8'h01);
        wr(13'h102, 8'hff);
        chk("cm_gen_powerdown", 16'h0001, {15'h0, cm_gen_powerdown});
        rd(13'h102, 8'h08);
        wr(13'h030, 8'h55);
        rd(13'h030, 8'h00);
    endtask : t_immediate

    // rate override held back until the transfer bit
    task automatic t_staged;
        wr(13'h100, 8'h45);
        chk("rate_override_en", 16'h0000, {15'h0, rate_override_en});
        chk("rate_code", 16'h0000, {13'h0, rate_code});
        rd(13'h100, 8'h45);
        wr(13'h0ff, 8'h01);
        chk("rate_override_en", 16'h0001, {15'h0, rate_override_en});
        chk("rate_code", 16'h0005, {13'h0, rate_code});
        rd(13'h0ff, 8'h00);
    endtask : t_staged

    // local writes follow the channel index, global ones ignore it
    task automatic t_index;
        wr(13'h005, 8'h02);
        wr(13'h022, 8'h01);
        chk("chan_powerdown", 16'h0002, {10'h0, chan_powerdown});
        wr(13'h005, 8'h10);
        wr(13'h022, 8'h02);
        chk("chan_out_reset", 16'h0010, {10'h0, chan_out_reset});
        chk("chan_powerdown", 16'h0002, {10'h0, chan_powerdown});
        wr(13'h01a, 8'h81);
        chk("pattern_one", 16'h81a5, pattern_one);
    endtask : t_index

    // sync enable and next-only arming
    task automatic t_sync;
        int s0;
        s0 = syncs;
        sync_event();
        chk("sync pulses", 16'h0000, 16'(syncs - s0));
        wr(13'h109, 8'h01);
        s0 = syncs;
        sync_event();
        sync_event();
        chk("sync pulses", 16'h0002, 16'(syncs - s0));
        wr(13'h109, 8'h03);
        s0 = syncs;
        sync_event();
        sync_event();
        chk("sync pulses", 16'h0001, 16'(syncs - s0));
        rd(13'h109, 8'h03);
    endtask : t_sync

    task automatic conclude;
        $display("compares %0d, fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        rst = 1'b1;
        sync_in = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_immediate();
        t_staged();
        t_index();
        t_sync();
        conclude();
    end
endmodule : tb_top
